// ==== include/sca_pkg.sv ====
// Package for the shared counter array: register offsets, field positions, reset values.
// Assumes an 8-bit special-function register port with 8-bit addresses.
package sca_pkg;
    // Register offsets
    localparam logic [7:0] SCA_ADDR_FLAGS  = 8'hd8;
    localparam logic [7:0] SCA_ADDR_AMODE  = 8'hd9;
    localparam logic [7:0] SCA_ADDR_MODE0  = 8'hda;
    localparam logic [7:0] SCA_ADDR_MODE1  = 8'hdb;
    localparam logic [7:0] SCA_ADDR_CNTL   = 8'he9;
    localparam logic [7:0] SCA_ADDR_CMP0L  = 8'hea;
    localparam logic [7:0] SCA_ADDR_CMP1L  = 8'heb;
    localparam logic [7:0] SCA_ADDR_EXT0   = 8'hf2;
    localparam logic [7:0] SCA_ADDR_EXT1   = 8'hf3;
    localparam logic [7:0] SCA_ADDR_CNTH   = 8'hf9;
    localparam logic [7:0] SCA_ADDR_CMP0H  = 8'hfa;
    localparam logic [7:0] SCA_ADDR_CMP1H  = 8'hfb;
    // Field positions in array_control_flags
    localparam int SCA_FLAGS_OVF  = 7;
    localparam int SCA_FLAGS_RUN  = 6;
    localparam int SCA_FLAGS_EV1  = 1;
    localparam int SCA_FLAGS_EV0  = 0;
    // Field position in array_mode_register
    localparam int SCA_AMODE_OIE  = 0;
    // Field positions in a module mode register
    localparam int SCA_MODE_CMP   = 6;
    localparam int SCA_MODE_RISE  = 5;
    localparam int SCA_MODE_FALL  = 4;
    localparam int SCA_MODE_MAT   = 3;
    localparam int SCA_MODE_TOG   = 2;
    localparam int SCA_MODE_PWM   = 1;
    localparam int SCA_MODE_IE    = 0;
    // Field positions in a pwm extension register
    localparam int SCA_EXT_RELOAD = 1;
    localparam int SCA_EXT_ACTIVE = 0;
    // Reset values
    localparam logic [7:0] SCA_RST_BYTE = 8'h00;
    localparam logic [6:0] SCA_RST_MODE = 7'h00;
    localparam logic [1:0] SCA_RST_EXT  = 2'h0;
    // Default count tick divider (system clock / 12)
    localparam int SCA_TICK_DIV = 12;
endpackage

// ==== src/sca_module.sv ====
// One capture/compare/PWM module of the shared counter array.
// Assumes the pin input is synchronous to clock and the counter value is stable per cycle.
`timescale 1ns/1ps
`default_nettype none
module sca_module
    import sca_pkg::*;
(
    input  wire logic        clock,       // System clock
    input  wire logic        rst_n,       // Synchronous reset, active low
    input  wire logic [6:0]  mode,        // Module mode bits
    input  wire logic [15:0] count,       // Shared counter value
    input  wire logic        tick,        // Counter advances this cycle
    input  wire logic        pin_in,      // Module pin level
    input  wire logic [15:0] cmp_val,     // Compare register pair
    input  wire logic        ext_active,  // Active extension bit
    input  wire logic        ext_reload,  // Reload extension bit
    output logic             capture,     // Load count into the pair
    output logic             event_set,   // Set the event flag
    output logic             reload,      // Reload active PWM value
    output logic             pin_out,     // Pin output level
    output logic             pin_oe       // Pin output enable
);
    logic pin_q;
    logic out_q;
    logic out_d;
    wire comp_en = mode[SCA_MODE_CMP];
    wire rise_en = mode[SCA_MODE_RISE];
    wire fall_en = mode[SCA_MODE_FALL];
    wire mat_en  = mode[SCA_MODE_MAT];
    wire tog_en  = mode[SCA_MODE_TOG];
    wire pwm_en  = mode[SCA_MODE_PWM];
    wire ie_en   = mode[SCA_MODE_IE];

    // Match only counts once per counter value, so sample it on the tick
    wire match   = comp_en && tick && (count == cmp_val);
    wire pin_r   = pin_in && !pin_q;
    wire pin_f   = !pin_in && pin_q;
    wire cap_mode = !mat_en && !tog_en && !pwm_en && (rise_en || fall_en);
    wire edge_hit = (rise_en && pin_r) || (fall_en && pin_f);
    wire pwm_mode = comp_en && pwm_en;
    // Low phase while the low byte is below the nine-bit active value
    wire pwm_low  = {1'b0, count[7:0]} < {ext_active, cmp_val[7:0]};
    wire out_r    = out_d && !out_q;
    wire out_f    = !out_d && out_q;

    // Output level: PWM compare or toggle on match
    always_comb begin
        out_d = out_q;
        if (pwm_mode) begin
            out_d = !pwm_low;
        end else if (tog_en && match) begin
            out_d = !out_q;
        end
    end

    assign capture   = cap_mode && edge_hit;
    // PWM edge events only reach the flag when the module interrupt is chosen
    assign event_set = capture || (!pwm_mode && mat_en && match)
                       || (pwm_mode && ie_en && ((rise_en && out_r) || (fall_en && out_f)));
    assign reload    = pwm_mode && tick && (count[7:0] == 8'hff);

    // Pin history and output latch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_q <= 1'b1;  // Pin idles high on its pull-up, so no false edge
            out_q <= 1'b1;
        end else begin
            pin_q <= pin_in;
            out_q <= out_d;
        end
    end

    // The pin drives only in output modes so capture sees the outside world
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_out <= 1'b1;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= out_d;
            pin_oe  <= pwm_mode || (comp_en && tog_en);
        end
    end
    wire unused_reload = ext_reload;
endmodule
`default_nettype wire

// ==== src/sca_top.sv ====
// Shared counter array: 16-bit counter, two capture/compare/PWM modules, register port.
// Assumes a CPU core driving a one-cycle register write strobe and combinational-address reads.
`timescale 1ns/1ps
`default_nettype none
module sca_top
    import sca_pkg::*;
#(
    parameter int TICK_DIV = SCA_TICK_DIV  // System clocks per count tick
)(
    input  wire logic       clock,         // System clock, 50 MHz
    input  wire logic       rst_n,         // Synchronous reset, active low
    input  wire logic [7:0] reg_addr,      // Register address
    input  wire logic [7:0] reg_wdata,     // Register write data
    input  wire logic       reg_wr,        // Register write strobe
    input  wire logic       reg_rd,        // Register read strobe
    output logic      [7:0] reg_rdata,     // Registered read data
    output logic            irq,           // Interrupt request
    input  wire logic       module0_io_pin_in,  // Module 0 pin level
    output logic            module0_io_pin_out, // Module 0 pin drive
    output logic            module0_io_pin_oe,  // Module 0 pin enable
    input  wire logic       module1_io_pin_in,  // Module 1 pin level
    output logic            module1_io_pin_out, // Module 1 pin drive
    output logic            module1_io_pin_oe   // Module 1 pin enable
);
    localparam logic [7:0] TICK_LAST = 8'(TICK_DIV - 1);

    logic       ovf_q, run_q, oie_q;
    logic [1:0] ev_q;
    logic [6:0] mode_q [2];
    logic [7:0] cmpl_q [2];
    logic [7:0] cmph_q [2];
    logic [1:0] ext_q  [2];
    logic [15:0] cnt_q;
    logic [7:0]  div_q;
    logic [1:0] cap_w, ev_w, rl_w, po_w, pe_w;

    // Write decode per register; strobe and address come in as arguments so that
    // a continuous assignment calling this is re-evaluated whenever they change
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] a);
        return wr && (addr == a);
    endfunction

    wire tick       = run_q && (div_q == TICK_LAST);
    wire cnt_wrap   = tick && (cnt_q == 16'hffff);
    wire wr_flags   = wr_hit(reg_wr, reg_addr, SCA_ADDR_FLAGS);
    wire wr_cntl    = wr_hit(reg_wr, reg_addr, SCA_ADDR_CNTL);
    wire wr_cnth    = wr_hit(reg_wr, reg_addr, SCA_ADDR_CNTH);
    wire [7:0] flags_rd = {ovf_q, run_q, 4'h0, ev_q};

    // Count tick divider; the counter source selection is not built in
    always_ff @(posedge clock) begin
        if (!rst_n || !run_q || div_q == TICK_LAST) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // Counter; a software byte write wins over the tick
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_q <= {SCA_RST_BYTE, SCA_RST_BYTE};
        end else if (wr_cntl) begin
            cnt_q[7:0] <= reg_wdata;
        end else if (wr_cnth) begin
            cnt_q[15:8] <= reg_wdata;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Control flags; hardware set wins over a software clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
            run_q <= 1'b0;
            ev_q  <= 2'b00;
            oie_q <= 1'b0;
        end else begin
            if (wr_flags) begin
                run_q <= reg_wdata[SCA_FLAGS_RUN];
            end
            if (wr_hit(reg_wr, reg_addr, SCA_ADDR_AMODE)) begin
                oie_q <= reg_wdata[SCA_AMODE_OIE];
            end
            ovf_q <= cnt_wrap || (wr_flags ? reg_wdata[SCA_FLAGS_OVF] : ovf_q);
            ev_q[1] <= ev_w[1] || (wr_flags ? reg_wdata[SCA_FLAGS_EV1] : ev_q[1]);
            ev_q[0] <= ev_w[0] || (wr_flags ? reg_wdata[SCA_FLAGS_EV0] : ev_q[0]);
        end
    end

    // Per-module registers and instances
    for (genvar m = 0; m < 2; m++) begin : g_mod
        wire [7:0] a_mode = m ? SCA_ADDR_MODE1 : SCA_ADDR_MODE0;
        wire [7:0] a_cl   = m ? SCA_ADDR_CMP1L : SCA_ADDR_CMP0L;
        wire [7:0] a_ch   = m ? SCA_ADDR_CMP1H : SCA_ADDR_CMP0H;
        wire [7:0] a_ext  = m ? SCA_ADDR_EXT1  : SCA_ADDR_EXT0;
        wire       pin_i  = m ? module1_io_pin_in : module0_io_pin_in;

        // Capture overrides a same-cycle software write to the pair
        always_ff @(posedge clock) begin
            if (!rst_n) begin
                mode_q[m] <= SCA_RST_MODE;
                cmpl_q[m] <= SCA_RST_BYTE;
                cmph_q[m] <= SCA_RST_BYTE;
                ext_q[m]  <= SCA_RST_EXT;
            end else begin
                if (wr_hit(reg_wr, reg_addr, a_mode)) begin
                    mode_q[m] <= reg_wdata[6:0];
                end
                if (cap_w[m]) begin
                    {cmph_q[m], cmpl_q[m]} <= cnt_q;
                end else if (rl_w[m]) begin
                    cmpl_q[m] <= cmph_q[m];
                    ext_q[m][SCA_EXT_ACTIVE] <= ext_q[m][SCA_EXT_RELOAD];
                end else begin
                    if (wr_hit(reg_wr, reg_addr, a_cl)) begin
                        cmpl_q[m] <= reg_wdata;
                    end
                    if (wr_hit(reg_wr, reg_addr, a_ch)) begin
                        cmph_q[m] <= reg_wdata;
                    end
                    if (wr_hit(reg_wr, reg_addr, a_ext)) begin
                        ext_q[m] <= reg_wdata[1:0];
                    end
                end
            end
        end

        sca_module u_mod (
            .clock      (clock),
            .rst_n      (rst_n),
            .mode       (mode_q[m]),
            .count      (cnt_q),
            .tick       (tick),
            .pin_in     (pin_i),
            .cmp_val    ({cmph_q[m], cmpl_q[m]}),
            .ext_active (ext_q[m][SCA_EXT_ACTIVE]),
            .ext_reload (ext_q[m][SCA_EXT_RELOAD]),
            .capture    (cap_w[m]),
            .event_set  (ev_w[m]),
            .reload     (rl_w[m]),
            .pin_out    (po_w[m]),
            .pin_oe     (pe_w[m])
        );
    end

    // Read selection; reserved bits read as zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == SCA_ADDR_FLAGS) begin
            rd_mux = flags_rd;
        end else if (reg_addr == SCA_ADDR_AMODE) begin
            rd_mux = {7'h00, oie_q};
        end else if (reg_addr == SCA_ADDR_MODE0) begin
            rd_mux = {1'b0, mode_q[0]};
        end else if (reg_addr == SCA_ADDR_MODE1) begin
            rd_mux = {1'b0, mode_q[1]};
        end else if (reg_addr == SCA_ADDR_CNTL) begin
            rd_mux = cnt_q[7:0];
        end else if (reg_addr == SCA_ADDR_CNTH) begin
            rd_mux = cnt_q[15:8];
        end else if (reg_addr == SCA_ADDR_CMP0L) begin
            rd_mux = cmpl_q[0];
        end else if (reg_addr == SCA_ADDR_CMP1L) begin
            rd_mux = cmpl_q[1];
        end else if (reg_addr == SCA_ADDR_CMP0H) begin
            rd_mux = cmph_q[0];
        end else if (reg_addr == SCA_ADDR_CMP1H) begin
            rd_mux = cmph_q[1];
        end else if (reg_addr == SCA_ADDR_EXT0) begin
            rd_mux = {6'h00, ext_q[0]};
        end else if (reg_addr == SCA_ADDR_EXT1) begin
            rd_mux = {6'h00, ext_q[1]};
        end
    end

    // Interrupt request from enabled flags
    wire irq_d = (ovf_q && oie_q)
                 || (ev_q[0] && mode_q[0][SCA_MODE_IE])
                 || (ev_q[1] && mode_q[1][SCA_MODE_IE]);

    // Registered outputs, one cycle behind the internal state
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata          <= 8'h00;
            irq                <= 1'b0;
            module0_io_pin_out <= 1'b1;
            module0_io_pin_oe  <= 1'b0;
            module1_io_pin_out <= 1'b1;
            module1_io_pin_oe  <= 1'b0;
        end else begin
            reg_rdata          <= reg_rd ? rd_mux : reg_rdata;
            irq                <= irq_d;
            module0_io_pin_out <= po_w[0];
            module0_io_pin_oe  <= pe_w[0];
            module1_io_pin_out <= po_w[1];
            module1_io_pin_oe  <= pe_w[1];
        end
    end

    // Checks
    property p_ovf_set;
        @(posedge clock) disable iff (!rst_n) cnt_wrap |=> ovf_q;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow");

    property p_ovf_hold;
        @(posedge clock) disable iff (!rst_n) (ovf_q && !wr_flags) |=> ovf_q;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow cleared by hardware");

    property p_stop;
        @(posedge clock) disable iff (!rst_n)
            (!run_q && !wr_cntl && !wr_cnth) |=> cnt_q == $past(cnt_q);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_ev1;
        @(posedge clock) disable iff (!rst_n) ev_w[1] |=> ev_q[1];
    endproperty
    a_ev1: assert property (p_ev1) else $error("module 1 flag not set");

    property p_ev0;
        @(posedge clock) disable iff (!rst_n) ev_w[0] |=> ev_q[0];
    endproperty
    a_ev0: assert property (p_ev0) else $error("module 0 flag not set");

    property p_cap;
        @(posedge clock) disable iff (!rst_n)
            cap_w[0] |=> {cmph_q[0], cmpl_q[0]} == $past(cnt_q);
    endproperty
    a_cap: assert property (p_cap) else $error("capture value wrong");

    property p_irq_ovf;
        @(posedge clock) disable iff (!rst_n) (ovf_q && oie_q) |=> irq;
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("overflow interrupt missing");

    property p_irq_none;
        @(posedge clock) disable iff (!rst_n)
            (!oie_q && !mode_q[0][SCA_MODE_IE] && !mode_q[1][SCA_MODE_IE]) |=> !irq;
    endproperty
    a_irq_none: assert property (p_irq_none) else $error("interrupt without enable");

    property p_count;
        @(posedge clock) disable iff (!rst_n)
            (tick && !wr_cntl && !wr_cnth) |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");

    property p_reload;
        @(posedge clock) disable iff (!rst_n) rl_w[0] && !cap_w[0] |=> cmpl_q[0] == $past(cmph_q[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("pwm reload wrong");

    // The extension bit travels with the low byte at the same wrap
    property p_reload_ext;
        @(posedge clock) disable iff (!rst_n)
            (rl_w[0] && !cap_w[0])
            |=> ext_q[0][SCA_EXT_ACTIVE] == $past(ext_q[0][SCA_EXT_RELOAD]);
    endproperty
    a_reload_ext: assert property (p_reload_ext) else $error("ext reload wrong");

    // Module 1 capture lands the counter value just as module 0 does
    property p_cap1;
        @(posedge clock) disable iff (!rst_n)
            cap_w[1] |=> {cmph_q[1], cmpl_q[1]} == $past(cnt_q);
    endproperty
    a_cap1: assert property (p_cap1) else $error("module 1 capture wrong");

    // An enabled event flag reaches the request line one cycle later
    property p_irq_ev0;
        @(posedge clock) disable iff (!rst_n) (ev_q[0] && mode_q[0][SCA_MODE_IE]) |=> irq;
    endproperty
    a_irq_ev0: assert property (p_irq_ev0) else $error("module 0 interrupt missing");

    property p_irq_ev1;
        @(posedge clock) disable iff (!rst_n) (ev_q[1] && mode_q[1][SCA_MODE_IE]) |=> irq;
    endproperty
    a_irq_ev1: assert property (p_irq_ev1) else $error("module 1 interrupt missing");

    // Run bit follows software writes and nothing else
    property p_run;
        @(posedge clock) disable iff (!rst_n)
            wr_flags |=> run_q == $past(reg_wdata[SCA_FLAGS_RUN]);
    endproperty
    a_run: assert property (p_run) else $error("run bit not written");

    // Software may raise the overflow flag as well
    property p_ovf_sw;
        @(posedge clock) disable iff (!rst_n)
            (wr_flags && reg_wdata[SCA_FLAGS_OVF]) |=> ovf_q;
    endproperty
    a_ovf_sw: assert property (p_ovf_sw) else $error("overflow set lost");

    // Hardware never clears an event flag; only a flag write may
    property p_ev0_hold;
        @(posedge clock) disable iff (!rst_n) (ev_q[0] && !wr_flags) |=> ev_q[0];
    endproperty
    a_ev0_hold: assert property (p_ev0_hold) else $error("module 0 flag lost");

    // A module with every mode bit clear raises no event
    property p_idle0;
        @(posedge clock) disable iff (!rst_n) (mode_q[0] == SCA_RST_MODE) |-> !ev_w[0];
    endproperty
    a_idle0: assert property (p_idle0) else $error("idle module raised an event");

    // PWM mode claims the pin two registers after the mode bits
    property p_pwm_oe0;
        @(posedge clock) disable iff (!rst_n)
            (mode_q[0][SCA_MODE_CMP] && mode_q[0][SCA_MODE_PWM]) |=> ##1 module0_io_pin_oe;
    endproperty
    a_pwm_oe0: assert property (p_pwm_oe0) else $error("pwm pin not driven");

    c_wrap:    cover property (@(posedge clock) cnt_wrap);
    c_capture: cover property (@(posedge clock) cap_w[1]);
    c_reload:  cover property (@(posedge clock) rl_w[0]);
    c_irq:     cover property (@(posedge clock) irq);
    c_pwm_ev:  cover property (@(posedge clock) ev_w[0] && mode_q[0][SCA_MODE_PWM]);
endmodule
`default_nettype wire

// ==== tb/sca_pin_model.sv ====
// Pin model for the two module pins: a pull-up, an outside driver and the block's drive.
// Assumes the block's pin outputs are registered and hold steady between clock edges.
`timescale 1ns/1ps
`default_nettype none
module sca_pin_model (
    input  wire logic [1:0] pin_out,  // Block pin drive
    input  wire logic [1:0] pin_oe,   // Block pin enable
    input  wire logic [1:0] ext_en,   // Outside driver enable
    input  wire logic [1:0] ext_lvl,  // Outside driver level
    output logic      [1:0] pin       // Resolved pin level
);
    // Block drive wins; an undriven pin floats high on its pull-up
    assign pin = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_lvl) | ~ext_en));
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the shared counter array, count tick shortened to every clock.
// Assumes the pin model of sca_pin_model and the register port contract of the block.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sca_pkg::*;
;
    logic       clock;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       irq;
    wire  [1:0] pin_out;
    wire  [1:0] pin_oe;
    logic [1:0] pin;
    logic [1:0] ext_en;
    logic [1:0] ext_lvl;
    int         errors = 0;
    int         num_checks = 0;
    // Mapped places plus one unmapped place, all zero after reset
    localparam logic [7:0] RST_A [13] = '{8'hd8, 8'hd9, 8'hda, 8'hdb, 8'he9, 8'hea,
        8'heb, 8'hf2, 8'hf3, 8'hf9, 8'hfa, 8'hfb, 8'h80};
    // Address, write data, read-back value with reserved bits at zero
    localparam logic [23:0] WR_TBL [10] = '{24'hda8101, 24'hdb8101, 24'hd9ff01,
        24'hf2ff03, 24'hf3ff03, 24'heaa5a5, 24'hfa5a5a, 24'heb3c3c, 24'hfbc3c3, 24'h80ff00};
    localparam logic [7:0] CAP [3] = '{8'h20, 8'h10, 8'h31};
    localparam logic [7:0] PE [3] = '{8'h63, 8'h53, 8'h73};

    sca_top #(.TICK_DIV(1)) dut_u (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .module0_io_pin_in(pin[0]), .module0_io_pin_out(pin_out[0]),
        .module0_io_pin_oe(pin_oe[0]), .module1_io_pin_in(pin[1]),
        .module1_io_pin_out(pin_out[1]), .module1_io_pin_oe(pin_oe[1])
    );

    sca_pin_model pins_u (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin(pin)
    );

    // 50 MHz system clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Run limit, in case the block stops answering altogether
    initial begin
        repeat (100000) @(posedge clock);
        errors++;
        end_sim();
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // One-cycle write strobe; the next access waits for a fresh edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read, then compare once the registered data has surely landed
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        @(negedge clock);
        chk(n, e, reg_rdata);
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Bounded wait for pin 0 to reach a level
    task automatic wait_pin(input logic lvl);
        int k;
        k = 0;
        while (pin[0] !== lvl && k < 600) begin
            @(negedge clock);
            k++;
        end
        if (pin[0] !== lvl) begin
            errors++;
            end_sim();
        end
    endtask

    // Low cycles of pin 0 over exactly two PWM periods
    task automatic pwm_low(input int e);
        int n;
        n = 0;
        repeat (512) begin
            @(negedge clock);
            if (pin[0] === 1'b0) n++;
        end
        chk("pwm low cycles", e[15:0], n[15:0]);
    endtask

    // Main sequence: reset, registers, counter, timer, capture, PWM
    initial begin
        logic [7:0] v;
        logic       hit;
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        ext_en    = 2'b00;
        ext_lvl   = 2'b11;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        foreach (RST_A[i])
            rdc("reset value", RST_A[i], 8'h00);
        chk("pin drives", 2'b11, pin_out);
        chk("pin enables", 2'b00, pin_oe);
        foreach (WR_TBL[i]) begin
            wr(WR_TBL[i][23:16], WR_TBL[i][15:8]);
            rdc("register", WR_TBL[i][23:16], WR_TBL[i][7:0]);
        end
        wr(8'hda, 8'h00);
        wr(8'hdb, 8'h00);
        wr(8'hd9, 8'h00);
        // Flags set by software; interrupt needs its enable
        wr(8'hd8, 8'h83);
        rdc("flags", 8'hd8, 8'h83);
        chk("irq", 1'b0, irq);
        wr(8'hd9, 8'h01);
        idle(4);
        chk("irq", 1'b1, irq);
        wr(8'hd8, 8'h00);
        rdc("flags", 8'hd8, 8'h00);
        chk("irq", 1'b0, irq);
        // Counter holds while stopped, then wraps and flags overflow
        wr(8'he9, 8'hfe);
        wr(8'hf9, 8'hff);
        idle(6);
        rdc("counter low", 8'he9, 8'hfe);
        wr(8'hd8, 8'h40);
        idle(10);
        rdc("flags", 8'hd8, 8'hc0);
        chk("irq", 1'b1, irq);
        rdc("counter high", 8'hf9, 8'h00);
        wr(8'hd8, 8'h40);
        rdc("flags", 8'hd8, 8'h40);
        wr(8'hd8, 8'h00);
        wr(8'hd9, 8'h00);
        // Module 0 fast output at 0x0110; module 1 set to match 0x0010 with comparator off, so it never matches
        wr(8'he9, 8'h00);
        wr(8'hf9, 8'h00);
        wr(8'hea, 8'h10);
        wr(8'hfa, 8'h01);
        wr(8'hda, 8'h4d);
        wr(8'heb, 8'h10);
        wr(8'hfb, 8'h00);
        wr(8'hdb, 8'h08);
        wr(8'hd8, 8'h40);
        idle(100);
        rdc("flags", 8'hd8, 8'h40);
        idle(200);
        rdc("flags", 8'hd8, 8'h41);
        chk("irq", 1'b1, irq);
        chk("pin0", 1'b0, pin[0]);
        chk("pin0 enable", 1'b1, pin_oe[0]);
        wr(8'hd8, 8'h00);
        wr(8'hda, 8'h00);
        wr(8'hdb, 8'h00);
        // Capture on each edge choice, counter stopped at a known value
        wr(8'hf9, 8'h5a);
        ext_en <= 2'b11;
        for (int m = 0; m < 2; m++) begin
            for (int r = 0; r < 3; r++) begin
                wr(8'hda + 8'(m), CAP[r]);
                for (int e = 0; e < 2; e++) begin
                    v = 8'h21 + 8'(m * 8 + r * 2 + e);
                    hit = CAP[r][e ? SCA_MODE_RISE : SCA_MODE_FALL];
                    wr(8'he9, v);
                    wr(8'hea + 8'(m), 8'h00);
                    wr(8'hd8, 8'h00);
                    @(posedge clock);
                    ext_lvl[m] <= e[0];
                    idle(4);
                    rdc("event flags", 8'hd8, 8'(hit) << m);
                    chk("irq", hit & CAP[r][SCA_MODE_IE], irq);
                    rdc("capture low", 8'hea + 8'(m), hit ? v : 8'h00);
                end
            end
        end
        rdc("capture high", 8'hfa, 8'h5a);
        rdc("capture high", 8'hfb, 8'h5a);
        wr(8'hda, 8'h00);
        wr(8'hdb, 8'h00);
        ext_en <= 2'b00;
        // PWM duty, reload at low byte wrap, nine-bit extension
        wr(8'hf2, 8'h00);
        wr(8'hea, 8'h40);
        wr(8'hfa, 8'h40);
        wr(8'hda, 8'h42);
        wr(8'hd8, 8'h40);
        idle(300);
        pwm_low(128);
        chk("irq", 1'b0, irq);
        chk("pin0 enable", 1'b1, pin_oe[0]);
        wr(8'hfa, 8'hc0);
        idle(300);
        pwm_low(384);
        rdc("compare low", 8'hea, 8'hc0);
        wr(8'hfa, 8'h00);
        wr(8'hf2, 8'h02);
        idle(300);
        pwm_low(512);
        rdc("extension", 8'hf2, 8'h03);
        wr(8'hf2, 8'h00);
        wr(8'hfa, 8'h80);
        idle(300);
        // PWM output edges raise the event only on the chosen edges
        foreach (PE[r]) begin
            wr(8'hda, PE[r]);
            wait_pin(1'b0);
            idle(4);
            wr(8'hd8, 8'h40);
            wait_pin(1'b1);
            idle(4);
            rdc("rise event", 8'hd8, 8'h40 | 8'(PE[r][SCA_MODE_RISE]));
            wr(8'hd8, 8'h40);
            wait_pin(1'b0);
            idle(4);
            rdc("fall event", 8'hd8, 8'h40 | 8'(PE[r][SCA_MODE_FALL]));
            chk("irq", PE[r][SCA_MODE_FALL], irq);
        end
        wr(8'hd8, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
